// file: supervisor_pkg.sv
/*
 * shared constants for the clock supervision block: register indices,
 * field positions, reset values, service codes and divider figures.
 * assumes a 32-bit apb register bus with one word per register.
 */
package supervisor_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_PERIODIC_CTRL = 10'h014;
	localparam logic [9:0] IDX_PERIODIC_FLAG = 10'h015;
	localparam logic [9:0] IDX_WATCHDOG_CTRL = 10'h016;
	localparam logic [9:0] IDX_WATCHDOG_SVC = 10'h017;
	localparam logic [9:0] IDX_SLOW_DIV = 10'h0e0;
	localparam logic [9:0] IDX_MODE_STATUS = 10'h0f0;

	// relocation window is 2 kbyte
	localparam int PAGE_BITS = 11;

	// periodic_irq_control fields
	localparam int PIC_ENABLE = 7;
	localparam int PIC_HALT_WAIT = 6;
	localparam int PIC_HALT_DEBUG = 5;
	localparam int PIC_BYPASS = 3;
	localparam int PIC_RATE_LSB = 0;

	// periodic_irq_flag field
	localparam int PIF_FLAG = 7;

	// watchdog_control fields
	localparam int WDC_WATCH_EN = 7;
	localparam int WDC_WATCH_FORCE_EN = 6;
	localparam int WDC_WATCH_FORCE_RST = 5;
	localparam int WDC_FORCE_RST = 4;
	localparam int WDC_RST_DISABLE = 3;
	localparam int WDC_RATE_LSB = 0;

	// reset values
	localparam logic [7:0] PIC_RESET = 8'h00;
	localparam logic [7:0] WDC_RESET = 8'h01;
	localparam logic [2:0] WDC_RATE_RESET = 3'h1;
	localparam logic [7:0] SLOW_RESET = 8'h00;

	// watchdog service codes
	localparam logic [7:0] SVC_FIRST = 8'h55;
	localparam logic [7:0] SVC_SECOND = 8'haa;

	// divider chain: normal prescale stages and stages kept in bypass
	localparam int PRESCALE_STAGES = 13;
	localparam int BYPASS_STAGES = 2;

	// slow divider counter width, covers divide by 128
	localparam int SLOW_CNT_W = 7;

	// watchdog service sequence
	typedef enum logic [1:0] {
		SVC_IDLE = 2'b01,
		SVC_ARMED = 2'b10
	} svc_state_e;

endpackage

// file: slow_divider.sv
/*
 * slow clock divider: produces the global bus tick, divided by two to
 * the divisor field in wait mode, and every cycle otherwise.
 * assumes the divisor and wait_mode are synchronous to pclk.
 */
`timescale 1ns/1ns
module slow_divider
	import supervisor_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic wait_mode,
	input wire logic [2:0] divisor,
	// global tick
	output logic slow_tick
);

	logic [SLOW_CNT_W-1:0] cnt_reg;
	logic [SLOW_CNT_W-1:0] cnt_next;
	logic [SLOW_CNT_W-1:0] limit;
	wire bypass;
	wire wrap;

	assign bypass = (divisor == 3'h0) || !wait_mode;
	assign limit = SLOW_CNT_W'((8'h01 << divisor) - 8'h01);
	assign wrap = (cnt_reg >= limit);
	assign cnt_next = (bypass || wrap) ? '0 : cnt_reg + 1'b1;
	assign slow_tick = bypass || wrap;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

endmodule

// file: clock_watch.sv
/*
 * clock monitor: turns the rc delay cell's no-edge indication into a
 * system reset request without needing any running clock.
 * assumes rc_window_expired comes from an analog rc delay cell.
 */
`timescale 1ns/1ns
module clock_watch (
	// rc delay cell
	input wire logic rc_window_expired,
	// control
	input wire logic clock_watch_enable,
	input wire logic clock_watch_force_enable,
	input wire logic clock_watch_force_reset,
	input wire logic supervisor_reset_disable,
	// reset request
	output logic clock_fail_reset
);

	wire armed;

	assign armed = clock_watch_enable || clock_watch_force_enable;
	// purely combinational so it acts while clocks are stopped
	assign clock_fail_reset = !supervisor_reset_disable && armed &&
		(rc_window_expired || clock_watch_force_reset);

endmodule

// file: clock_supervisor.sv
/*
 * clock supervision: apb register bank, clock tick generation, periodic
 * interrupt, watchdog with service sequence, and clock monitor reset.
 * assumes mode inputs are synchronous to pclk and a system reset
 * controller acts on the reset request outputs.
 */
`timescale 1ns/1ns
// Notes on behaviour
// - wait mode keeps slowed and fixed clock families
// - peripheral, bus and four phase clocks generated
// - slow divider only active in wait, nonzero
// - slow divide by two to the field
// - watchdog rate zero disables timeout and force, else seven periods
// - timeout without ordered service pair resets
// - wrong service value resets at once
// - periodic tick at seven selectable rates
// - request equals enable and flag together
// - halt-in-wait stops both timers in wait
// - halt-in-debug stops both timers in debug
// - halt bits write once in normal modes
// - bypass only in special, shortens chain
// - clock monitor resets without running clock
// - register bank relocatable on 2 kbyte pages
// - writing one clears periodic flag
// - periodic rates two to 13 through 19
// - watchdog totals two to 13 through 23
// - reset disable blocks both reset sources
module clock_supervisor
	import supervisor_pkg::*;
#(
	parameter int PRESCALE_SHIFT = PRESCALE_STAGES
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// bank placement
	input wire logic [31-PAGE_BITS:0] bank_page,
	// part modes
	input wire logic special_mode,
	input wire logic wait_mode,
	input wire logic debug_mode,
	// rc delay cell
	input wire logic rc_window_expired,
	// clock ticks
	output logic periph_tick,
	output logic bus_tick,
	output logic fixed_rate_wait_clock,
	output logic [3:0] cpu_phase,
	// interrupt and resets
	output logic periodic_irq,
	output logic watchdog_reset,
	output logic clock_fail_reset
);

	localparam int CNT_W = PRESCALE_SHIFT + 11;

	// mask of the low k bits of a chain counter
	function automatic logic [CNT_W-1:0] low_mask(input int k);
		low_mask = CNT_W'((64'h1 << k) - 64'h1);
	endfunction

	// stages added by the watchdog rate field
	function automatic int cop_extra(input logic [2:0] r);
		unique case (r)
			3'h1: cop_extra = 0;
			3'h2: cop_extra = 2;
			3'h3: cop_extra = 4;
			3'h4: cop_extra = 6;
			3'h5: cop_extra = 8;
			3'h6: cop_extra = 9;
			3'h7: cop_extra = 10;
			default: cop_extra = 0;
		endcase
	endfunction

	// register state
	logic periodic_irq_enable;
	logic halt_timers_in_wait;
	logic halt_timers_in_debug;
	logic periodic_divider_bypass;
	logic [2:0] periodic_rate;
	logic periodic_irq_flag_bit;
	logic clock_watch_enable;
	logic clock_watch_force_enable;
	logic clock_watch_force_reset;
	logic watchdog_force_reset;
	logic supervisor_reset_disable;
	logic [2:0] watchdog_rate;
	logic [2:0] slow_divisor;
	logic pic_written_reg;
	logic wdc_written_reg;
	logic init_done_reg;
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rd_word;
	logic [CNT_W-1:0] pre_cnt_reg;
	logic [CNT_W-1:0] cop_cnt_reg;
	logic [3:0] phase_reg;
	logic half_rate_reg;
	logic watchdog_reset_reg;
	svc_state_e svc_reg;
	svc_state_e svc_next;

	// bus decode
	wire in_page = (paddr[31:PAGE_BITS] == bank_page);
	wire [9:0] idx = 10'(paddr[PAGE_BITS-1:2]);
	wire word_ok = (paddr[1:0] == 2'b00) && in_page;
	wire hit_pic = word_ok && (idx == IDX_PERIODIC_CTRL);
	wire hit_pif = word_ok && (idx == IDX_PERIODIC_FLAG);
	wire hit_wdc = word_ok && (idx == IDX_WATCHDOG_CTRL);
	wire hit_svc = word_ok && (idx == IDX_WATCHDOG_SVC);
	wire hit_slow = word_ok && (idx == IDX_SLOW_DIV);
	wire hit_stat = word_ok && (idx == IDX_MODE_STATUS);
	wire mapped = hit_pic || hit_pif || hit_wdc || hit_svc || hit_slow || hit_stat;
	wire access = psel && penable;
	wire done = access && pready_reg;
	wire wr = done && pwrite && mapped;
	wire [7:0] wbyte = pwdata[7:0];

	// write qualifiers
	wire wr_pic = wr && hit_pic;
	wire wr_wdc = wr && hit_wdc;
	wire pic_once_ok = special_mode || !pic_written_reg;
	wire wdc_once_ok = special_mode || !wdc_written_reg;

	// watchdog service decode
	wire svc_wr = wr && hit_svc;
	wire svc_first = svc_wr && (wbyte == SVC_FIRST);
	wire svc_second = svc_wr && (wbyte == SVC_SECOND);
	wire svc_bad = svc_wr && !svc_first && !svc_second;
	wire svc_done = svc_second && (svc_reg == SVC_ARMED);

	// timer run control
	wire halted = (wait_mode && halt_timers_in_wait) ||
		(debug_mode && halt_timers_in_debug);
	wire run = !halted;
	wire bypass_eff = periodic_divider_bypass && special_mode;
	wire [7:0] base_k = bypass_eff ? 8'(BYPASS_STAGES) : 8'(PRESCALE_SHIFT);

	// periodic tick and watchdog expiry
	wire [CNT_W-1:0] rti_mask = low_mask(int'(base_k) + int'(periodic_rate) - 1);
	wire rti_tick = run && (periodic_rate != 3'h0) &&
		((pre_cnt_reg & rti_mask) == rti_mask);
	wire [CNT_W-1:0] cop_mask = low_mask(int'(base_k) + cop_extra(watchdog_rate));
	wire cop_on = (watchdog_rate != 3'h0);
	wire cop_expire = run && cop_on && ((cop_cnt_reg & cop_mask) == cop_mask);
	wire cop_force = watchdog_force_reset && cop_on && special_mode;
	wire cop_fault = (cop_expire || svc_bad || cop_force) && !supervisor_reset_disable;

	// slow global tick and fixed-rate family
	slow_divider u_slow (
		.pclk(pclk),
		.presetn(presetn),
		.wait_mode(wait_mode),
		.divisor(slow_divisor),
		.slow_tick(bus_tick)
	);

	clock_watch u_watch (
		.rc_window_expired(rc_window_expired),
		.clock_watch_enable(clock_watch_enable),
		.clock_watch_force_enable(clock_watch_force_enable),
		.clock_watch_force_reset(clock_watch_force_reset && special_mode),
		.supervisor_reset_disable(supervisor_reset_disable),
		.clock_fail_reset(clock_fail_reset)
	);

	assign periph_tick = bus_tick;
	assign fixed_rate_wait_clock = half_rate_reg;
	assign cpu_phase = phase_reg;

	assign periodic_irq = periodic_irq_enable && periodic_irq_flag_bit;
	assign watchdog_reset = watchdog_reset_reg;
	assign pready = pready_reg;
	assign pslverr = done && !mapped;
	assign prdata = prdata_reg;

	// read mux
	always_comb begin
		rd_word = 32'h0;
		if (hit_pic) begin
			rd_word[7:0] = {periodic_irq_enable, halt_timers_in_wait, halt_timers_in_debug,
				1'b0, periodic_divider_bypass, periodic_rate};
		end else if (hit_pif) begin
			rd_word[PIF_FLAG] = periodic_irq_flag_bit;
		end else if (hit_wdc) begin
			rd_word[7:0] = {clock_watch_enable, clock_watch_force_enable,
				clock_watch_force_reset, watchdog_force_reset,
				supervisor_reset_disable, watchdog_rate};
		end else if (hit_slow) begin
			rd_word[2:0] = slow_divisor;
		end else if (hit_stat) begin
			rd_word[3:0] = {svc_reg == SVC_ARMED, debug_mode, wait_mode, special_mode};
		end
	end

	// service sequence
	always_comb begin
		svc_next = svc_reg;
		unique case (svc_reg)
			SVC_IDLE: begin
				if (svc_first) begin
					svc_next = SVC_ARMED;
				end
			end
			SVC_ARMED: begin
				if (svc_done || svc_bad) begin
					svc_next = SVC_IDLE;
				end
			end
		endcase
	end

	// apb handshake: one wait state, read data registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end else begin
			pready_reg <= access && !pready_reg;
			if (access && !pready_reg && !pwrite) begin
				prdata_reg <= rd_word;
			end
		end
	end

	// periodic control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periodic_irq_enable <= PIC_RESET[PIC_ENABLE];
			halt_timers_in_wait <= PIC_RESET[PIC_HALT_WAIT];
			halt_timers_in_debug <= PIC_RESET[PIC_HALT_DEBUG];
			periodic_divider_bypass <= PIC_RESET[PIC_BYPASS];
			periodic_rate <= PIC_RESET[PIC_RATE_LSB +: 3];
			pic_written_reg <= 1'b0;
		end else if (wr_pic) begin
			periodic_irq_enable <= wbyte[PIC_ENABLE];
			periodic_rate <= wbyte[PIC_RATE_LSB +: 3];
			pic_written_reg <= 1'b1;
			if (pic_once_ok) begin
				halt_timers_in_wait <= wbyte[PIC_HALT_WAIT];
				halt_timers_in_debug <= wbyte[PIC_HALT_DEBUG];
			end
			if (special_mode) begin
				periodic_divider_bypass <= wbyte[PIC_BYPASS];
			end
		end
	end

	// periodic flag: a new tick wins over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periodic_irq_flag_bit <= 1'b0;
		end else if (rti_tick) begin
			periodic_irq_flag_bit <= 1'b1;
		end else if (wr && hit_pif && wbyte[PIF_FLAG]) begin
			periodic_irq_flag_bit <= 1'b0;
		end
	end

	// watchdog control register; reset-disable strap caught after release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_watch_enable <= WDC_RESET[WDC_WATCH_EN];
			clock_watch_force_enable <= WDC_RESET[WDC_WATCH_FORCE_EN];
			clock_watch_force_reset <= WDC_RESET[WDC_WATCH_FORCE_RST];
			watchdog_force_reset <= WDC_RESET[WDC_FORCE_RST];
			supervisor_reset_disable <= WDC_RESET[WDC_RST_DISABLE];
			watchdog_rate <= WDC_RATE_RESET;
			wdc_written_reg <= 1'b0;
			init_done_reg <= 1'b0;
		end else begin
			init_done_reg <= 1'b1;
			if (!init_done_reg) begin
				supervisor_reset_disable <= special_mode;
			end else if (wr_wdc) begin
				clock_watch_enable <= wbyte[WDC_WATCH_EN];
				wdc_written_reg <= 1'b1;
				if (wdc_once_ok) begin
					clock_watch_force_enable <= wbyte[WDC_WATCH_FORCE_EN];
					watchdog_rate <= wbyte[WDC_RATE_LSB +: 3];
				end
				if (special_mode) begin
					clock_watch_force_reset <= wbyte[WDC_WATCH_FORCE_RST];
					watchdog_force_reset <= wbyte[WDC_FORCE_RST];
					supervisor_reset_disable <= wbyte[WDC_RST_DISABLE];
				end
			end
		end
	end

	// slow divisor register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_divisor <= SLOW_RESET[2:0];
		end else if (wr && hit_slow) begin
			slow_divisor <= wbyte[2:0];
		end
	end

	// divider chains and watchdog count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt_reg <= '0;
			cop_cnt_reg <= '0;
		end else begin
			if (run) begin
				pre_cnt_reg <= pre_cnt_reg + 1'b1;
			end
			if (svc_done || !cop_on || cop_expire) begin
				cop_cnt_reg <= '0;
			end else if (run) begin
				cop_cnt_reg <= cop_cnt_reg + 1'b1;
			end
		end
	end

	// service state, reset request, clock phases
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			svc_reg <= SVC_IDLE;
			watchdog_reset_reg <= 1'b0;
			phase_reg <= 4'h1;
			half_rate_reg <= 1'b0;
		end else begin
			svc_reg <= svc_next;
			watchdog_reset_reg <= cop_fault;
			half_rate_reg <= !half_rate_reg;
			if (bus_tick) begin
				phase_reg <= {phase_reg[2:0], phase_reg[3]};
			end
		end
	end

endmodule

// file: clock_supervisor_checker.sv
/*
 port checker for clock_supervisor: bus timing, clock ticks, reset requests.
 assumes it is bound to the design top and sees its ports only.
*/
`timescale 1ns/1ns
module clock_supervisor_checker
	import supervisor_pkg::*;
(
	// clock and bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31-PAGE_BITS:0] bank_page,
	// modes
	input wire logic wait_mode,
	input wire logic special_mode,
	input wire logic rc_window_expired,
	// outputs
	input wire logic periph_tick,
	input wire logic bus_tick,
	input wire logic fixed_rate_wait_clock,
	input wire logic [3:0] cpu_phase,
	input wire logic periodic_irq,
	input wire logic watchdog_reset,
	input wire logic clock_fail_reset
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_phase_onehot: assert property ($onehot(cpu_phase))
		else $error("cpu phase not one-hot");
	a_phase_step: assert property (presetn && bus_tick |=> cpu_phase == {
		$past(cpu_phase[2:0]), $past(cpu_phase[3])}) else $error("cpu phase did not rotate");
	a_phase_hold: assert property (presetn && !bus_tick |=> $stable(cpu_phase))
		else $error("cpu phase moved without tick");
	a_periph_same: assert property (periph_tick == bus_tick)
		else $error("peripheral tick differs from bus tick");
	a_tick_free: assert property (!wait_mode && $past(!wait_mode) |-> bus_tick)
		else $error("bus tick slowed outside wait");
	a_fixed_toggle: assert property ($past(presetn) |->
		fixed_rate_wait_clock != $past(fixed_rate_wait_clock)) else $error("fixed clock stuck");
	a_ready_time: assert property (psel && penable && !pready |=> pready)
		else $error("no ready in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_page_err: assert property (psel && penable && pready && paddr[31:11] != bank_page
		|-> pslverr) else $error("off-page access not refused");
	a_fail_cause: assert property (clock_fail_reset |-> rc_window_expired || special_mode)
		else $error("clock fail reset without cause");

	cover property ($rose(periodic_irq));
	cover property (watchdog_reset);
	cover property (pslverr && pready);
	cover property (clock_fail_reset);
endmodule

// file: clock_supervisor_tb.sv
/*
 testbench for clock_supervisor: registers, periodic interrupt, slow divider,
 watchdog service and clock monitor. assumes PRESCALE_SHIFT set to 4.
*/
`timescale 1ns/1ns
module clock_supervisor_tb
	import supervisor_pkg::*;
;
	localparam int PS = 4;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, seen;
	logic special_mode, wait_mode, debug_mode, rc_window_expired, periodic_irq;
	logic periph_tick, bus_tick, fixed_rate_wait_clock, watchdog_reset, clock_fail_reset;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [31-PAGE_BITS:0] bank_page;
	logic [3:0] cpu_phase;
	int failures, num_checks, cyc, t0;

	clock_supervisor #(.PRESCALE_SHIFT(PS)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .bank_page, .special_mode, .wait_mode,
		.debug_mode, .rc_window_expired, .periph_tick, .bus_tick, .fixed_rate_wait_clock,
		.cpu_phase, .periodic_irq, .watchdog_reset, .clock_fail_reset);

	initial begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (watchdog_reset === 1'b1) seen <= 1;
	end

	task print_verdict();
		if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	function automatic logic [31:0] ad(input logic [9:0] i);
		return {20'h0, i, 2'b00};
	endfunction

	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failures++;
			print_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task wait_irq();
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (periodic_irq !== 1'b1 && n < 300);
		if (periodic_irq !== 1'b1) begin
			failures++;
			print_verdict();
		end
	endtask

	task rst(input logic sp);
		special_mode <= sp;
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
	endtask

	task s_regs();
		logic [9:0] idx [5];
		logic [7:0] val [5];
		idx = '{IDX_PERIODIC_CTRL, IDX_PERIODIC_FLAG, IDX_WATCHDOG_CTRL, IDX_WATCHDOG_SVC,
			IDX_SLOW_DIV};
		val = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
		rst(0);
		for (int i = 0; i < 5; i++) begin
			apb(0, ad(idx[i]), 0);
			chk("reset value", rd, {24'h0, val[i]});
			chk("mapped error", er, 0);
		end
		apb(0, 32'h3fc, 0);
		chk("unmapped error", er, 1);
		apb(1, ad(IDX_PERIODIC_CTRL), 32'h68);
		apb(1, ad(IDX_PERIODIC_CTRL), 32'h80);
		apb(0, ad(IDX_PERIODIC_CTRL), 0);
		chk("write once", rd, 32'he0);
		for (int i = 0; i < 2; i++) begin
			{wait_mode, debug_mode} <= i ? 2'b01 : 2'b10;
			apb(1, ad(IDX_PERIODIC_CTRL), 32'h81);
			apb(1, ad(IDX_PERIODIC_FLAG), 32'h80);
			repeat (40) @(posedge pclk);
			chk("halted irq", periodic_irq, 0);
			{wait_mode, debug_mode} <= 2'b00;
			wait_irq();
			chk("resumed irq", periodic_irq, 1);
		end
	endtask

	task s_periodic();
		rst(0);
		apb(1, ad(IDX_WATCHDOG_CTRL), 0);
		seen = 0;
		for (int r = 1; r < 4; r += 2) begin
			apb(1, ad(IDX_PERIODIC_CTRL), 32'h80 | r);
			apb(1, ad(IDX_PERIODIC_FLAG), 32'h80);
			wait_irq();
			t0 = cyc;
			apb(1, ad(IDX_PERIODIC_FLAG), 32'h00);
			apb(1, ad(IDX_PERIODIC_FLAG), 32'h80);
			@(posedge pclk);
			chk("flag cleared", periodic_irq, 0);
			wait_irq();
			chk("period", cyc - t0, 1 << (PS + r - 1));
		end
		apb(1, ad(IDX_PERIODIC_CTRL), 32'h01);
		apb(1, ad(IDX_PERIODIC_FLAG), 32'h80);
		repeat (40) @(posedge pclk);
		chk("masked irq", periodic_irq, 0);
		apb(0, ad(IDX_PERIODIC_FLAG), 0);
		chk("flag set", rd, 32'h80);
		chk("watchdog off", seen, 0);
	endtask

	task s_slow();
		int n;
		for (int d = 0; d < 8; d++) begin
			apb(1, ad(IDX_SLOW_DIV), d);
			wait_mode <= 1;
			n = 0;
			repeat (128) begin
				@(posedge pclk);
				n += bus_tick;
			end
			wait_mode <= 0;
			chk("tick count", n, 128 >> d);
		end
	endtask

	task svc();
		apb(1, ad(IDX_WATCHDOG_SVC), 32'h55);
		apb(1, ad(IDX_WATCHDOG_SVC), 32'haa);
	endtask

	task s_watchdog();
		rst(0);
		apb(1, ad(IDX_WATCHDOG_CTRL), 32'h02);
		apb(1, ad(IDX_WATCHDOG_CTRL), 32'h07);
		apb(0, ad(IDX_WATCHDOG_CTRL), 0);
		chk("rate locked", rd, 32'h02);
		seen = 0;
		repeat (10) svc();
		chk("serviced", seen, 0);
		apb(1, ad(IDX_WATCHDOG_SVC), 32'h12);
		repeat (3) @(posedge pclk);
		chk("bad code", seen, 1);
		svc();
		seen = 0;
		repeat (15) apb(1, ad(IDX_WATCHDOG_SVC), 32'h55);
		chk("early timeout", seen, 0);
		repeat (5) apb(1, ad(IDX_WATCHDOG_SVC), 32'h55);
		chk("timeout", seen, 1);
	endtask

	task s_special();
		rst(1);
		apb(0, ad(IDX_WATCHDOG_CTRL), 0);
		chk("special reset", rd, 32'h09);
		rc_window_expired <= 1;
		apb(1, ad(IDX_WATCHDOG_CTRL), 32'h89);
		@(posedge pclk);
		chk("fail blocked", clock_fail_reset, 0);
		seen = 0;
		apb(1, ad(IDX_WATCHDOG_SVC), 32'h12);
		repeat (3) @(posedge pclk);
		chk("watchdog blocked", seen, 0);
		apb(1, ad(IDX_WATCHDOG_CTRL), 32'h80);
		@(posedge pclk);
		chk("clock fail", clock_fail_reset, 1);
		rc_window_expired <= 0;
		apb(1, ad(IDX_PERIODIC_CTRL), 32'h68);
		apb(1, ad(IDX_PERIODIC_CTRL), 32'h08);
		apb(0, ad(IDX_PERIODIC_CTRL), 0);
		chk("special writes", rd, 32'h08);
		apb(1, ad(IDX_PERIODIC_CTRL), 32'h8b);
		wait_irq();
		t0 = cyc;
		apb(1, ad(IDX_PERIODIC_FLAG), 32'h80);
		wait_irq();
		chk("bypass period", cyc - t0, 1 << (BYPASS_STAGES + 2));
		bank_page <= 1;
		apb(0, 32'h800 | ad(IDX_WATCHDOG_CTRL), 0);
		chk("moved bank", rd, 32'h80);
		apb(0, ad(IDX_WATCHDOG_CTRL), 0);
		chk("old page", er, 1);
	endtask

	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		bank_page = 0;
		special_mode = 0;
		wait_mode = 0;
		debug_mode = 0;
		rc_window_expired = 0;
		s_regs();
		s_periodic();
		s_slow();
		s_watchdog();
		s_special();
		print_verdict();
	end
endmodule

bind clock_supervisor clock_supervisor_checker watch (.pclk, .presetn, .psel, .penable,
	.paddr, .pready, .pslverr, .bank_page, .wait_mode, .special_mode, .rc_window_expired,
	.periph_tick, .bus_tick, .fixed_rate_wait_clock, .cpu_phase, .periodic_irq,
	.watchdog_reset, .clock_fail_reset);
